/* core/orp_ramp_protect.sv */
// output ramp sequencer, slew/threshold registers and protection compare
//
// Summary of operation
// [RL1] target moves in 10 mV steps; step hold time sets slew rate
// [RL2] step time is a division of the shared master clock tick
// [RL3] slew register: rise code 6:4, turn-off slew enable 3, fall code 2:0
// [RL4] overcurrent trips during ramp when measured current exceeds threshold
// [RL5] with pre-bias, output drive waits until ramp target passes sensed output
// [RL6] fall rate selectable independent of rise; off delay shorter than on delay
// [RL7] warnings: thermal, power good; faults: oc, ov, ot, track; error: uv only
// [RL8] manager writes protection register only while run control is zero
// [RL9] bit 5 picks 105 or 110 percent high; bit 4 picks 95 or 90 percent low
// [RL10] bits 3:2 overvoltage level, bits 1:0 undervoltage level, code 01 120/80
// [RL11] slewed turn-off ramps within off delay; otherwise delay ends switches off; the code starts the ramp once the off delay has ended
// [RL12] power good low whenever output is outside the good window
// [RL13] unimplemented upper register bits read zero, writes ignored
// [RL14] ramp stops exactly at setpoint, no partial step overshoot
`timescale 1ns/1ns
`default_nettype none
`include "orp_consts.svh"
module orp_ramp_protect
  import orp_pkg::*;
#(
  parameter int RISE_OFF_MAX_MS = 255,
  parameter int FALL_OFF_MAX_MS = 63
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        run_enable,
  input  wire logic        master_tick,
  input  wire logic        ms_tick,
  input  wire logic [7:0]  on_delay_ms,
  input  wire logic [5:0]  off_delay_ms,
  input  wire logic [15:0] setpoint_mv,
  input  wire logic [15:0] vout_mv,
  input  wire logic [15:0] iout_ma,
  input  wire logic [15:0] ocp_ma,
  input  wire logic        temp_warn,
  input  wire logic        temp_over,
  output logic      [15:0] target_mv,
  output logic             drive_enable,
  output logic             switches_off,
  output logic             power_good_output,
  output logic             warn_thermal,
  output logic             warn_power_good,
  output logic             fault_overcurrent,
  output logic             fault_overvolt,
  output logic             fault_overtemp,
  output logic             fault_tracking,
  output logic             error_undervolt
);
  initial begin
    if (FALL_OFF_MAX_MS >= RISE_OFF_MAX_MS || FALL_OFF_MAX_MS > 63 || RISE_OFF_MAX_MS > 255)
      $error("orp: off delay range must be below on delay range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] prot_ff;
  logic [7:0] slew_ff;
  wire        wr_prot = reg_wr && reg_addr == `ORP_ADDR_PROT && !run_enable; // RL8
  wire        wr_slew = reg_wr && reg_addr == `ORP_ADDR_SLEW;
  wire  [7:0] nxt_prot = reg_wdata & `ORP_PROT_MASK; // RL13
  wire  [7:0] nxt_slew = reg_wdata & `ORP_SLEW_MASK; // RL13

  // register write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_ff <= `ORP_PROT_RESET;
      slew_ff <= `ORP_SLEW_RESET;
    end else begin
      if (wr_prot) prot_ff <= nxt_prot;
      if (wr_slew) slew_ff <= nxt_slew; // RL3
    end
  end

  // read mux, unmapped reads zero
  assign reg_rdata = (reg_addr == `ORP_ADDR_PROT) ? prot_ff :
                     (reg_addr == `ORP_ADDR_SLEW) ? slew_ff : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire [2:0] rise_code = slew_ff[`ORP_RISE_MSB:`ORP_RISE_LSB]; // RL3
  wire [2:0] fall_code = slew_ff[`ORP_FALL_MSB:`ORP_FALL_LSB]; // RL6
  wire       turnoff_slew_enable = slew_ff[`ORP_TSE_BIT];
  wire       good_window_high_sel = prot_ff[`ORP_PGH_BIT];
  wire       good_window_low_sel  = prot_ff[`ORP_PGL_BIT];
  wire [1:0] ov_code = prot_ff[`ORP_OVL_MSB:`ORP_OVL_LSB];
  wire [1:0] uv_code = prot_ff[`ORP_UVL_MSB:`ORP_UVL_LSB];

  // slew code to master ticks per step: code 0 slowest, halving upward
  function automatic logic [7:0] step_ticks(input logic [2:0] code);
    step_ticks = 8'h80 >> code;
  endfunction : step_ticks

  // percentage threshold of setpoint, computed in 32 bits
  function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [31:0] prod;
    prod = 32'(v) * 32'(p);
    pct = 16'(prod / 32'd100);
  endfunction : pct

  // threshold percentages
  wire [7:0] pg_hi_pct = good_window_high_sel ? 8'd105 : 8'd110; // RL9
  wire [7:0] pg_lo_pct = good_window_low_sel ? 8'd95 : 8'd90;    // RL9
  wire [7:0] ov_pct = (ov_code == 2'b00) ? 8'd110 : (ov_code == 2'b01) ? 8'd120 :
                      (ov_code == 2'b10) ? 8'd130 : 8'd140;       // RL10
  wire [7:0] uv_pct = (uv_code == 2'b00) ? 8'd75 : (uv_code == 2'b01) ? 8'd80 :
                      (uv_code == 2'b10) ? 8'd85 : 8'd90;         // RL10
  wire [15:0] pg_hi_mv = pct(setpoint_mv, pg_hi_pct);
  wire [15:0] pg_lo_mv = pct(setpoint_mv, pg_lo_pct);
  wire [15:0] ov_mv    = pct(setpoint_mv, ov_pct);
  wire [15:0] uv_mv    = pct(setpoint_mv, uv_pct);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  orp_state_e state_ff, nxt_state;
  logic [15:0] tgt_ff, nxt_tgt;
  logic [7:0]  tick_ff, nxt_tick;
  logic [7:0]  dly_ff, nxt_dly;
  logic        drv_ff, nxt_drv;
  logic        fault_any;

  wire [7:0] cur_ticks = (state_ff == ORP_FALL) ? step_ticks(fall_code)
                                                : step_ticks(rise_code); // RL2
  wire       step_due = master_tick && (tick_ff + 8'd1 >= cur_ticks);    // RL2
  wire [15:0] up_next = (setpoint_mv - tgt_ff < `ORP_STEP_MV) ? setpoint_mv
                        : 16'(tgt_ff + `ORP_STEP_MV);                     // RL14
  wire [15:0] dn_next = (tgt_ff < `ORP_STEP_MV) ? 16'h0000
                        : 16'(tgt_ff - `ORP_STEP_MV);                     // RL1

  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_tgt   = tgt_ff;
    nxt_dly   = dly_ff;
    nxt_drv   = drv_ff;
    nxt_tick  = master_tick ? (step_due ? 8'h00 : 8'(tick_ff + 8'd1)) : tick_ff;
    case (state_ff)
      ORP_IDLE: begin
        nxt_tgt = 16'h0000;
        nxt_drv = 1'b0;
        nxt_tick = 8'h00;
        if (run_enable && !fault_any) begin
          if (dly_ff >= on_delay_ms) begin
            nxt_state = ORP_RISE;
            nxt_dly = 8'h00;
          end else if (ms_tick) begin
            nxt_dly = 8'(dly_ff + 8'd1);
          end
        end else begin
          nxt_dly = 8'h00;
        end
      end
      ORP_RISE: begin
        if (!drv_ff && tgt_ff >= vout_mv) nxt_drv = 1'b1; // RL5
        if (!run_enable || fault_any) begin
          nxt_state = ORP_OFFWAIT;
          nxt_dly = 8'h00;
          if (fault_any) nxt_drv = 1'b0; // fast turn-off on a fault
        end else if (step_due) begin
          nxt_tgt = up_next; // RL1
          if (up_next == setpoint_mv) nxt_state = ORP_STEADY; // RL14
        end
      end
      ORP_STEADY: begin
        nxt_tgt = setpoint_mv;
        nxt_drv = 1'b1;
        if (!run_enable || fault_any) begin
          nxt_state = ORP_OFFWAIT;
          nxt_dly = 8'h00;
          if (fault_any) nxt_drv = 1'b0; // fast turn-off on a fault
        end
      end
      ORP_OFFWAIT: begin
        // slewed off: wait the whole off delay, then ramp down after it
        if (fault_any) begin
          nxt_state = ORP_IDLE;
        end else if (dly_ff >= {2'b00, off_delay_ms}) begin
          nxt_state = turnoff_slew_enable ? ORP_FALL : ORP_IDLE; // RL11
          nxt_dly = 8'h00;
        end else if (ms_tick) begin
          nxt_dly = 8'(dly_ff + 8'd1);
        end
      end
      ORP_FALL: begin
        if (fault_any) begin
          nxt_state = ORP_IDLE;
        end else if (step_due) begin
          nxt_tgt = dn_next; // RL6
          if (dn_next == 16'h0000) nxt_state = ORP_IDLE;
        end
      end
      default: nxt_state = ORP_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ORP_IDLE;
      tgt_ff   <= 16'h0000;
      tick_ff  <= 8'h00;
      dly_ff   <= 8'h00;
      drv_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tgt_ff   <= nxt_tgt;
      tick_ff  <= nxt_tick;
      dly_ff   <= nxt_dly;
      drv_ff   <= nxt_drv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection compare, registered
  wire active   = drv_ff && (state_ff != ORP_IDLE);
  wire steady   = state_ff == ORP_STEADY;
  wire oc_now   = active && (iout_ma > ocp_ma);                            // RL4
  wire ov_now   = active && (vout_mv > ov_mv);
  wire uv_now   = steady && (vout_mv < uv_mv);
  wire tr_diff  = (vout_mv > tgt_ff) ? (vout_mv - tgt_ff > `ORP_TRACK_MV)
                                     : (tgt_ff - vout_mv > `ORP_TRACK_MV);
  wire tr_now   = (state_ff == ORP_RISE) && drv_ff && tr_diff;
  wire pg_in    = (vout_mv <= pg_hi_mv) && (vout_mv >= pg_lo_mv);          // RL12
  wire pg_now   = steady && pg_in;

  logic oc_ff, ov_ff, uv_ff, tr_ff, ot_ff, tw_ff, pg_ff;
  assign fault_any = oc_ff || ov_ff || tr_ff || ot_ff || uv_ff;

  // oc, ov, uv, track latched until run control drops; events win over release; temperature and good flags follow
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_ff <= 1'b0;
      ov_ff <= 1'b0;
      uv_ff <= 1'b0;
      tr_ff <= 1'b0;
      ot_ff <= 1'b0;
      tw_ff <= 1'b0;
      pg_ff <= 1'b0;
    end else begin
      oc_ff <= oc_now || (oc_ff && run_enable);
      ov_ff <= ov_now || (ov_ff && run_enable);
      uv_ff <= uv_now || (uv_ff && run_enable);
      tr_ff <= tr_now || (tr_ff && run_enable);
      ot_ff <= temp_over;
      tw_ff <= temp_warn;
      pg_ff <= pg_now; // RL12
    end
  end

  // outputs grouped by class
  assign target_mv         = tgt_ff;
  assign drive_enable      = drv_ff;
  assign switches_off      = !drv_ff;
  assign power_good_output = pg_ff;
  assign warn_thermal      = tw_ff;   // RL7
  assign warn_power_good   = !pg_ff && steady; // RL7
  assign fault_overcurrent = oc_ff;   // RL7
  assign fault_overvolt    = ov_ff;   // RL7
  assign fault_overtemp    = ot_ff;   // RL7
  assign fault_tracking    = tr_ff;   // RL7
  assign error_undervolt   = uv_ff;   // RL7
endmodule : orp_ramp_protect
`default_nettype wire

/* inc/orp_consts.svh */
// constants for the output ramp and protection block
`ifndef ORP_CONSTS_SVH
`define ORP_CONSTS_SVH
`define ORP_ADDR_PROT        8'h01
`define ORP_ADDR_SLEW        8'h03
`define ORP_PROT_RESET       8'h08
`define ORP_SLEW_RESET       8'h1C
`define ORP_PROT_MASK        8'h3F
`define ORP_SLEW_MASK        8'h7F
`define ORP_PGH_BIT          5
`define ORP_PGL_BIT          4
`define ORP_OVL_MSB          3
`define ORP_OVL_LSB          2
`define ORP_UVL_MSB          1
`define ORP_UVL_LSB          0
`define ORP_RISE_MSB         6
`define ORP_RISE_LSB         4
`define ORP_TSE_BIT          3
`define ORP_FALL_MSB         2
`define ORP_FALL_LSB         0
`define ORP_STEP_MV          16'd10
`define ORP_TRACK_MV         16'd250
`endif

/* inc/orp_pkg.sv */
// types for the output ramp and protection block
package orp_pkg;
  typedef enum logic [2:0] {
    ORP_IDLE    = 3'b000,
    ORP_RISE    = 3'b001,
    ORP_STEADY  = 3'b010,
    ORP_FALL    = 3'b011,
    ORP_OFFWAIT = 3'b100
  } orp_state_e;
  typedef logic [15:0] orp_mv_t;
endpackage : orp_pkg

/* verification/orp_mgr_model.sv */
// power manager model: shared master clock ticks and millisecond pacing
`timescale 1ns/1ns
`default_nettype none
module orp_mgr_model #(
  parameter int MASTER_DIV = 4,
  parameter int MS_DIV     = 50
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic      master_tick,
  output logic      ms_tick
);
  int cnt_ff;
  // free-running divider shared by every converter on the bus
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cnt_ff <= 0;
    else cnt_ff <= cnt_ff + 1;
  end
  // one-cycle ticks cut from the divider
  assign master_tick = (cnt_ff % MASTER_DIV) == MASTER_DIV - 1;
  assign ms_tick     = (cnt_ff % MS_DIV) == MS_DIV - 1;
endmodule : orp_mgr_model
`default_nettype wire

/* verification/orp_checker_properties.sv */
// port checker for the ramp and protection block
`timescale 1ns/1ns
`default_nettype none
module orp_checker (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        run_enable,
  input wire logic        master_tick,
  input wire logic [15:0] setpoint_mv,
  input wire logic [15:0] vout_mv,
  input wire logic [15:0] iout_ma,
  input wire logic [15:0] ocp_ma,
  input wire logic [15:0] target_mv,
  input wire logic        drive_enable,
  input wire logic        power_good_output,
  input wire logic        fault_overcurrent
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_step; target_mv > $past(target_mv) |-> target_mv - $past(target_mv) <= 16'h000A; endproperty
  a_step: assert property (p_step) else $error("rise step above 10 mV");
  property p_clamp; target_mv > $past(target_mv) |-> target_mv <= setpoint_mv; endproperty
  a_clamp: assert property (p_clamp) else $error("target passed setpoint");
  property p_tick; target_mv > $past(target_mv) |-> $past(master_tick); endproperty
  a_tick: assert property (p_tick) else $error("step without master tick");
  property p_bias; $rose(drive_enable) |-> target_mv >= vout_mv; endproperty
  a_bias: assert property (p_bias) else $error("drive before target crossed output");
  property p_wr; reg_wr && reg_addr == 8'h03 ##1 reg_addr == 8'h03
    |-> reg_rdata == ($past(reg_wdata) & 8'h7F); endproperty
  a_wr: assert property (p_wr) else $error("slew register readback wrong");
  property p_lock; reg_wr && reg_addr == 8'h01 && run_enable ##1 reg_addr == 8'h01
    |-> $stable(reg_rdata); endproperty
  a_lock: assert property (p_lock) else $error("threshold write taken while running");
  property p_pg; power_good_output |-> int'($past(vout_mv)) * 100 <= int'(setpoint_mv) * 110
    && int'($past(vout_mv)) * 100 >= int'(setpoint_mv) * 90; endproperty
  a_pg: assert property (p_pg) else $error("good flag outside window");
  property p_oc; run_enable && drive_enable && iout_ma > ocp_ma |-> ##[0:2] fault_overcurrent;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not flagged");
endmodule : orp_checker
bind orp_ramp_protect orp_checker orp_checker_inst (.sys_clk, .reset_n, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .run_enable, .master_tick, .setpoint_mv, .vout_mv, .iout_ma,
  .ocp_ma, .target_mv, .drive_enable, .power_good_output, .fault_overcurrent);
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the ramp and protection block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        sys_clk = 0, reset_n = 0, reg_wr = 0, run_enable = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, d;
  logic [15:0] setpoint_mv = 16'h00C8, vout_mv = 0, iout_ma = 0, target_mv;
  logic        master_tick, ms_tick, drive_enable, switches_off, power_good_output;
  logic        fault_overcurrent;
  int          mismatches = 0, checks_done = 0, i;
  always #5 sys_clk = ~sys_clk;
  orp_mgr_model orp_mgr_model_inst (.sys_clk, .reset_n, .master_tick, .ms_tick);
  orp_ramp_protect orp_ramp_protect_inst (.sys_clk, .reset_n, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .run_enable, .master_tick, .ms_tick, .on_delay_ms(8'h02),
    .off_delay_ms(6'h01), .setpoint_mv, .vout_mv, .iout_ma, .ocp_ma(16'h0064),
    .temp_warn(1'b0), .temp_over(1'b0), .target_mv, .drive_enable, .switches_off,
    .power_good_output, .warn_thermal(), .warn_power_good(), .fault_overcurrent,
    .fault_overvolt(), .fault_overtemp(), .fault_tracking(), .error_undervolt());
  ////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // a wait that ran out ends the run
  task automatic waited(input string nm, input logic ok);
    chk(nm, 16'h0001, {15'h0000, ok});
    if (ok !== 1'b1) final_report();
  endtask : waited
  task automatic wr(input logic [7:0] a, dat);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = dat;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge sys_clk);
    reg_addr = a;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  // unimplemented upper bits read back as zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a, dat);
    return (a == 8'h01) ? (dat & 8'h3F) : (a == 8'h03) ? (dat & 8'h7F) : 8'h00;
  endfunction : exp_rd
  // main sequence
  initial begin
    void'($urandom(73));
    repeat (2) @(negedge sys_clk);
    reset_n = 1;
    rd(8'h01, 8'h08);
    rd(8'h03, 8'h1C);
    rd(8'h02, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(8'h03, d);
      rd(8'h03, exp_rd(8'h03, d));
      wr(8'h01, ~d);
      rd(8'h01, exp_rd(8'h01, ~d));
    end
    wr(8'h01, 8'hC0);
    rd(8'h01, 8'h00);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h7F);
    vout_mv = 16'(5 + 10 * ($urandom % 15));
    run_enable = 1;
    wr(8'h01, 8'h3F);
    rd(8'h01, 8'h00);
    for (i = 0; i < 2000 && drive_enable !== 1'b1; i++) @(negedge sys_clk);
    waited("drive_enable", drive_enable);
    chk("prebias", 16'h0001, {15'h0000, target_mv >= vout_mv});
    @(negedge sys_clk);
    vout_mv = setpoint_mv;
    for (i = 0; i < 2000 && power_good_output !== 1'b1; i++) @(negedge sys_clk);
    waited("power_good_output", power_good_output);
    chk("target_mv", setpoint_mv, target_mv);
    run_enable = 0;
    for (i = 0; i < 2000 && !(target_mv === 0 && switches_off === 1); i++) @(negedge sys_clk);
    waited("ramp_down", target_mv === 16'h0000 && switches_off === 1'b1);
    vout_mv = 0;
    iout_ma = 16'h0065;
    run_enable = 1;
    for (i = 0; i < 2000 && fault_overcurrent !== 1'b1; i++) @(negedge sys_clk);
    waited("fault_overcurrent", fault_overcurrent);
    @(negedge sys_clk);
    chk("switches_off", 16'h0001, {15'h0000, switches_off});
    final_report();
  end
endmodule : tb_top
`default_nettype wire
